// *** fcw_hb_timer.sv ***
// Silence timer: counts milliseconds without activity, flags overrun
`timescale 1ns/1ps
module fcw_hb_timer
  import fcw_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic run,
  input wire logic activity,
  input wire logic ms_tick,
  input wire logic [15:0] limit_ms,
  output logic expired
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;

  // Saturates so a stalled master never wraps back to a healthy count
  always_comb begin
    cnt_nxt = cnt_r;
    if (!run || activity) begin
      cnt_nxt = '0;
    end else if (ms_tick && cnt_r != 16'hffff) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Only longer than the limit counts as silence
  assign expired = run && (cnt_r > limit_ms);
endmodule // fcw_hb_timer

// *** fcw_master.sv ***
// Fieldbus master model: writes word 5 with a heartbeat and analog values
`timescale 1ns/1ps
module fcw_master
  import fcw_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [1:0] mode,
  output logic [15:0] word,
  output logic wr,
  output fcw_ao_t ao
);
  logic [2:0] cnt_r;
  logic hb_r;
  // Mode 0 holds bit 15 high, 1 toggles it, 2 holds it low, 3 stops writing
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 3'h0;
      hb_r <= 1'b0;
      wr <= 1'b0;
      word <= 16'h0000;
      ao <= '0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      wr <= 1'b0;
      if (cnt_r == 3'h7 && mode != 2'h3) begin
        // Level mode leaves the toggle at one so a switch to toggling changes at once
        hb_r <= (mode == 2'h1) ? ~hb_r : 1'b1;
        wr <= 1'b1;
        word <= {(mode == 2'h1) ? ~hb_r : (mode == 2'h0), 15'($urandom)};
        ao <= 48'({$urandom, $urandom});
      end
    end
  end
endmodule // fcw_master

// *** fcw_ms_tick.sv ***
// Millisecond time base derived from the system clock
`timescale 1ns/1ps
module fcw_ms_tick
  import fcw_pkg::*;
#(
  parameter int CYC_PER_MS = FCW_CYC_PER_MS
) (
  input wire logic clock,
  input wire logic rstn,
  output logic tick
);
  localparam int CW = $clog2(CYC_PER_MS);
  localparam logic [CW-1:0] LAST = CW'(CYC_PER_MS - 1);

  if (CYC_PER_MS < 2) begin : g_bad
    $error("CYC_PER_MS must be at least 2");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  always_comb begin
    cnt_nxt = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    tick_nxt = (cnt_r == LAST);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;
endmodule // fcw_ms_tick

// *** fcw_pkg.sv ***
// Shared constants and types for the fieldbus configuration watchdog
package fcw_pkg;
  // Register offsets on the parameter address space
  localparam logic [12:0] FCW_ADDR_SETUP = 13'h0e6;
  localparam logic [12:0] FCW_ADDR_TMO = 13'h25b;
  localparam logic [12:0] FCW_ADDR_MASK = 13'h25c;
  localparam int FCW_ADDR_W = 13;
  localparam int FCW_DATA_W = 16;
  localparam int FCW_AO_N = 3;
  localparam int FCW_MASK_W = 3;

  // Reset values
  localparam logic [15:0] FCW_SETUP_RST = 16'h0000;
  localparam logic [15:0] FCW_TMO_RST = 16'h0000;
  localparam logic [2:0] FCW_MASK_RST = 3'h0;

  // Timeout range limit in milliseconds
  localparam logic [15:0] FCW_TMO_MAX_MS = 16'hea60;

  // Node address limits per fieldbus kind
  localparam logic [7:0] FCW_NODE_MAX_A = 8'h7e;
  localparam logic [7:0] FCW_NODE_MAX_B = 8'h3f;

  // Heartbeat bit inside the remote digital input word
  localparam int FCW_HB_BIT = 15;

  // Time base
  localparam int FCW_CLK_NS = 25;
  localparam int FCW_MS_NS = 1000000;
  localparam int FCW_CYC_PER_MS = FCW_MS_NS / FCW_CLK_NS;

  // Link rate codes
  localparam logic [3:0] FCW_RATE_125K = 4'h0;
  localparam logic [3:0] FCW_RATE_250K = 4'h1;
  localparam logic [3:0] FCW_RATE_500K = 4'h2;
  localparam logic [3:0] FCW_RATE_AUTO = 4'h3;

  // Heartbeat check types
  localparam logic [3:0] FCW_HB_LEVEL = 4'h0;
  localparam logic [3:0] FCW_HB_TOGGLE = 4'h1;
  localparam logic [3:0] FCW_HB_LINK = 4'h2;

  // Packed setup word: type 15..12, rate 11..8, node 7..0
  typedef struct packed {
    logic [3:0] heartbeat_check_type;
    logic [3:0] link_rate_code;
    logic [7:0] slave_node_number;
  } fcw_setup_t;

  // One value for each analog output
  typedef struct packed {
    logic [15:0] three;
    logic [15:0] two;
    logic [15:0] one;
  } fcw_ao_t;

  typedef enum logic [1:0] {
    FCW_BPS_125K,
    FCW_BPS_250K,
    FCW_BPS_500K,
    FCW_BPS_AUTO
  } fcw_bps_t;
endpackage

// *** fcw_top.sv ***
// Fieldbus configuration registers, analog output handover and link watchdog
`timescale 1ns/1ps
// Behaviour
// - The analog output handover mask is three bits, one per output, any mix allowed.
// - A handed-over analog output follows the master's value instead of the local one.
// - The node number is valid up to 126 or 63 by fieldbus kind, only on the designated board.
// - Rate codes 0..3 mean 125k, 250k, 500k and auto, used only by the second kind.
// - Node, rate code and check type share one 16-bit word at address 230.
// - With a zero timeout the heartbeat check never raises the alarm.
// - Supervision starts only after the first connection with the master.
// - Type 0 raises the alarm when the heartbeat bit stays low longer than the timeout.
// - Type 1 raises the alarm when the heartbeat bit stops toggling longer than the timeout.
// - Type 2 watches the designated board's link state instead of the heartbeat bit.
// - Any board other than the designated one forces check type 0.
// - The timeout is in milliseconds from 0 to 60000, zero disabling the alarm.
// - The alarm clears only on a reset command, once communication is healthy again or the timeout is zero.
module fcw_top
  import fcw_pkg::*;
#(
  parameter int CYC_PER_MS = FCW_CYC_PER_MS
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [12:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [15:0] remote_digital_input_word,
  input wire logic remote_word_wr,
  input wire fcw_ao_t ao_from_master,
  input wire fcw_ao_t ao_local,
  input wire logic board_designated,
  input wire logic fieldbus_kind_b,
  input wire logic board_link_up,
  input wire logic alarm_reset_cmd,
  output fcw_ao_t ao_out,
  output logic node_valid,
  output logic [7:0] slave_node_number,
  output logic link_rate_active,
  output fcw_bps_t link_rate,
  output logic [3:0] active_check_type,
  output logic supervision_armed,
  output logic comm_suspended_alarm
);
  // Register file
  fcw_setup_t setup_r;
  fcw_setup_t setup_nxt;
  logic [15:0] tmo_r;
  logic [15:0] tmo_nxt;
  logic [FCW_MASK_W-1:0] mask_r;
  logic [FCW_MASK_W-1:0] mask_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;

  always_comb begin
    setup_nxt = setup_r;
    tmo_nxt = tmo_r;
    mask_nxt = mask_r;
    if (reg_wr) begin
      case (reg_addr)
        FCW_ADDR_SETUP: setup_nxt = reg_wdata;
        // Out-of-range writes saturate rather than wrap to a short timeout
        FCW_ADDR_TMO: tmo_nxt = (reg_wdata > FCW_TMO_MAX_MS) ? FCW_TMO_MAX_MS
                                                             : reg_wdata;
        FCW_ADDR_MASK: mask_nxt = reg_wdata[FCW_MASK_W-1:0];
        default: ;
      endcase
    end
    rvalid_nxt = reg_rd;
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        FCW_ADDR_SETUP: rdata_nxt = setup_r;
        FCW_ADDR_TMO: rdata_nxt = tmo_r;
        FCW_ADDR_MASK: rdata_nxt = {13'h0000, mask_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      setup_r <= FCW_SETUP_RST;
      tmo_r <= FCW_TMO_RST;
      mask_r <= FCW_MASK_RST;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      setup_r <= setup_nxt;
      tmo_r <= tmo_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  // Analog output handover
  fcw_ao_t ao_r;
  fcw_ao_t ao_nxt;

  always_comb begin
    ao_nxt.one = mask_r[0] ? ao_from_master.one : ao_local.one;
    ao_nxt.two = mask_r[1] ? ao_from_master.two : ao_local.two;
    ao_nxt.three = mask_r[2] ? ao_from_master.three : ao_local.three;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ao_r <= '0;
    end else begin
      ao_r <= ao_nxt;
    end
  end

  assign ao_out = ao_r;

  // Link setup decode
  function automatic fcw_bps_t rate_decode(input logic [3:0] code);
    case (code)
      FCW_RATE_125K: rate_decode = FCW_BPS_125K;
      FCW_RATE_250K: rate_decode = FCW_BPS_250K;
      FCW_RATE_500K: rate_decode = FCW_BPS_500K;
      FCW_RATE_AUTO: rate_decode = FCW_BPS_AUTO;
      default: rate_decode = FCW_BPS_125K;
    endcase
  endfunction

  logic [7:0] node_limit;
  assign node_limit = fieldbus_kind_b ? FCW_NODE_MAX_B : FCW_NODE_MAX_A;
  assign slave_node_number = setup_r.slave_node_number;
  assign node_valid = board_designated
                      && (setup_r.slave_node_number <= node_limit);
  assign link_rate_active = board_designated && fieldbus_kind_b;
  assign link_rate = rate_decode(setup_r.link_rate_code);

  // Undefined check types fall back to the plain level check
  logic [3:0] eff_type;
  always_comb begin
    eff_type = FCW_HB_LEVEL;
    if (board_designated) begin
      case (setup_r.heartbeat_check_type)
        FCW_HB_TOGGLE: eff_type = FCW_HB_TOGGLE;
        FCW_HB_LINK: eff_type = FCW_HB_LINK;
        default: eff_type = FCW_HB_LEVEL;
      endcase
    end
  end
  assign active_check_type = eff_type;

  // Heartbeat tracking and arming
  logic hb_r;
  logic hb_nxt;
  logic armed_r;
  logic armed_nxt;
  logic hb_new;
  logic activity;
  logic first_contact;

  assign hb_new = remote_digital_input_word[FCW_HB_BIT];

  always_comb begin
    hb_nxt = remote_word_wr ? hb_new : hb_r;
    first_contact = (eff_type == FCW_HB_LINK) ? board_link_up
                                              : (remote_word_wr && hb_new);
    armed_nxt = armed_r || first_contact;
    case (eff_type)
      FCW_HB_LEVEL: activity = hb_r;
      FCW_HB_TOGGLE: activity = remote_word_wr && (hb_new != hb_r);
      FCW_HB_LINK: activity = board_link_up;
      default: activity = hb_r;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hb_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      hb_r <= hb_nxt;
      armed_r <= armed_nxt;
    end
  end

  assign supervision_armed = armed_r;

  // Silence timing
  logic ms_tick;
  logic expired;
  logic run;

  assign run = armed_r && (tmo_r != 16'h0000);

  fcw_ms_tick #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_tick (
    .clock(clock),
    .rstn(rstn),
    .tick(ms_tick)
  );

  fcw_hb_timer u_timer (
    .clock(clock),
    .rstn(rstn),
    .run(run),
    .activity(activity),
    .ms_tick(ms_tick),
    .limit_ms(tmo_r),
    .expired(expired)
  );

  // Alarm latch; a trip in the reset cycle wins over the clear
  logic alarm_r;
  logic alarm_nxt;
  logic healthy;
  logic hb_ok;

  // A toggle lasts one cycle, so a silence count back under the limit stands in for it
  assign hb_ok = (eff_type == FCW_HB_TOGGLE) || activity;
  // A zero timeout also lets the reset command clear a stuck alarm
  assign healthy = (tmo_r == 16'h0000) || (armed_r && !expired && hb_ok);

  always_comb begin
    alarm_nxt = alarm_r;
    if (alarm_reset_cmd && healthy) begin
      alarm_nxt = 1'b0;
    end
    if (expired) begin
      alarm_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      alarm_r <= 1'b0;
    end else begin
      alarm_r <= alarm_nxt;
    end
  end

  assign comm_suspended_alarm = alarm_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_ao_route: assert property (
    ##1 ao_r.one == ($past(mask_r[0]) ? $past(ao_from_master.one) : $past(ao_local.one))
  ) else $error("analog output one not routed by mask");

  chk_mask_width: assert property (
    $past(reg_wr) && $past(reg_addr) == FCW_ADDR_MASK
      |-> mask_r == $past(reg_wdata[2:0])
  ) else $error("mask register did not take written bits");

  chk_setup_pack: assert property (
    reg_wr && reg_addr == FCW_ADDR_SETUP
      |=> setup_r.heartbeat_check_type == $past(reg_wdata[15:12])
          && setup_r.slave_node_number == $past(reg_wdata[7:0])
  ) else $error("setup word fields misplaced");

  chk_tmo_off: assert property (
    tmo_r == 16'h0000 && !alarm_r |=> !alarm_r
  ) else $error("alarm raised with zero timeout");

  chk_not_armed: assert property (
    !armed_r && !alarm_r |=> !alarm_r
  ) else $error("alarm raised before first contact");

  chk_level_hold: assert property (
    eff_type == FCW_HB_LEVEL && hb_r && !alarm_r [*2] |=> !alarm_r
  ) else $error("alarm raised while heartbeat held high");

  chk_forced_type: assert property (
    !board_designated |-> eff_type == FCW_HB_LEVEL
  ) else $error("check type not forced on foreign board");

  chk_node_range: assert property (
    node_valid == (board_designated && slave_node_number
                   <= (fieldbus_kind_b ? FCW_NODE_MAX_B : FCW_NODE_MAX_A))
  ) else $error("node number validity wrong for fieldbus kind");

  chk_rate_scope: assert property (
    link_rate_active == (board_designated && fieldbus_kind_b)
  ) else $error("rate active outside second fieldbus kind");

  chk_link_hold: assert property (
    (eff_type == FCW_HB_LINK && board_link_up && !alarm_r) [*2] |=> !alarm_r
  ) else $error("alarm raised while board link stayed up");

  chk_alarm_clear: assert property (
    alarm_r ##1 !alarm_r |-> $past(alarm_reset_cmd) && $past(healthy)
  ) else $error("alarm cleared without reset on healthy link");

  chk_tmo_clamp: assert property (
    tmo_r <= FCW_TMO_MAX_MS
  ) else $error("timeout above range");
endmodule // fcw_top

// *** fcw_top_tb.sv ***
// Self-checking bench for the fieldbus configuration watchdog
`timescale 1ns/1ps
module fcw_top_tb
  import fcw_pkg::*;
;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [12:0] ra = '0;
  logic [15:0] wd = '0;
  logic rw = 1'b0;
  logic rr = 1'b0;
  logic [15:0] rdat;
  logic rv;
  logic [15:0] rdw;
  logic rwr;
  fcw_ao_t aom;
  fcw_ao_t aol = '0;
  fcw_ao_t aoo;
  logic des = 1'b1;
  logic kb = 1'b0;
  logic lnk = 1'b0;
  logic arst = 1'b0;
  logic nv;
  logic [7:0] node;
  logic ract;
  fcw_bps_t rate;
  logic [3:0] atyp;
  logic armed;
  logic alarm;
  logic [1:0] mode = 2'h2;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] v;
  logic [15:0] s;
  logic [12:0] adr [4] = '{FCW_ADDR_SETUP, FCW_ADDR_TMO, FCW_ADDR_MASK, 13'h0e7};
  always #12.5 clock = ~clock;
  fcw_top #(.CYC_PER_MS(4)) fcw_top_inst (.clock(clock), .rstn(rstn), .reg_addr(ra),
    .reg_wdata(wd), .reg_wr(rw), .reg_rd(rr), .reg_rdata(rdat), .reg_rvalid(rv),
    .remote_digital_input_word(rdw), .remote_word_wr(rwr), .ao_from_master(aom),
    .ao_local(aol), .board_designated(des), .fieldbus_kind_b(kb), .board_link_up(lnk),
    .alarm_reset_cmd(arst), .ao_out(aoo), .node_valid(nv), .slave_node_number(node),
    .link_rate_active(ract), .link_rate(rate), .active_check_type(atyp),
    .supervision_armed(armed), .comm_suspended_alarm(alarm));
  fcw_master fcw_master_inst (.clock(clock), .rstn(rstn), .mode(mode), .word(rdw),
    .wr(rwr), .ao(aom));
  task automatic give_verdict;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cn(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [12:0] a, input logic [15:0] d);
    cn(1);
    ra = a;
    wd = d;
    rw = 1'b1;
    cn(1);
    rw = 1'b0;
  endtask
  task automatic rd(input logic [12:0] a, output logic [15:0] d);
    cn(1);
    ra = a;
    rr = 1'b1;
    cn(1);
    rr = 1'b0;
    chk(rv, 1'b1);
    d = rdat;
  endtask
  task automatic pulse(input int n);
    arst = 1'b1;
    cn(n);
    arst = 1'b0;
    cn(2);
  endtask
  // Lower bound catches an alarm that fires before the silence has run its course
  task automatic wait_alarm;
    cn(12);
    chk(alarm, 1'b0);
    for (int i = 0; i < 40 && alarm !== 1'b1; i++) cn(1);
    chk(alarm, 1'b1);
  endtask
  function automatic fcw_ao_t exp_ao(logic [2:0] m, fcw_ao_t f, fcw_ao_t l);
    exp_ao.one = m[0] ? f.one : l.one;
    exp_ao.two = m[1] ? f.two : l.two;
    exp_ao.three = m[2] ? f.three : l.three;
  endfunction
  function automatic fcw_bps_t exp_rate(logic [3:0] c);
    return (c > 4'h3) ? FCW_BPS_125K : fcw_bps_t'(c[1:0]);
  endfunction
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    v = $urandom(47);
    cn(16);
    rstn = 1'b1;
    foreach (adr[i]) begin
      rd(adr[i], v);
      chk(v, 16'h0000);
    end
    wr(FCW_ADDR_TMO, 16'h0004);
    cn(60);
    chk(armed, 1'b0);
    chk(alarm, 1'b0);
    for (int i = 0; i < 32; i++) begin
      s = {4'(i), 4'(i), 8'(i[0] ? $urandom_range(62, 65) : $urandom_range(125, 128))};
      des = i[4];
      kb = 1'($urandom);
      wr(FCW_ADDR_SETUP, s);
      rd(FCW_ADDR_SETUP, v);
      chk(v, s);
      chk(node, s[7:0]);
      chk(nv, des && s[7:0] <= (kb ? 8'd63 : 8'd126));
      chk(ract, des && kb);
      chk(rate, exp_rate(s[11:8]));
      chk(atyp, (des && s[15:12] <= 4'h2) ? s[15:12] : 4'h0);
    end
    wr(FCW_ADDR_TMO, 16'h0000);
    mode = 2'h0;
    for (int m = 0; m < 8; m++) begin
      aol = 48'({$urandom, $urandom});
      wr(FCW_ADDR_MASK, {13'($urandom), 3'(m)});
      rd(FCW_ADDR_MASK, v);
      chk(v, 16'(m));
      while (rwr !== 1'b1) cn(1);
      cn(1);
      chk(aoo, exp_ao(3'(m), aom, aol));
    end
    chk(armed, 1'b1);
    mode = 2'h2;
    cn(80);
    chk(alarm, 1'b0);
    wr(FCW_ADDR_TMO, 16'hffff);
    rd(FCW_ADDR_TMO, v);
    chk(v, 16'hea60);
    des = 1'b1;
    wr(FCW_ADDR_SETUP, 16'h0005);
    wr(FCW_ADDR_TMO, 16'h0004);
    mode = 2'h0;
    cn(40);
    chk(alarm, 1'b0);
    mode = 2'h2;
    wait_alarm();
    pulse(1);
    chk(alarm, 1'b1);
    mode = 2'h0;
    cn(12);
    pulse(1);
    chk(alarm, 1'b0);
    des = 1'b0;
    wr(FCW_ADDR_SETUP, 16'h1005);
    cn(80);
    chk(alarm, 1'b0);
    des = 1'b1;
    mode = 2'h1;
    cn(80);
    chk(alarm, 1'b0);
    mode = 2'h3;
    wait_alarm();
    mode = 2'h1;
    pulse(10);
    chk(alarm, 1'b0);
    lnk = 1'b1;
    wr(FCW_ADDR_SETUP, 16'h2005);
    mode = 2'h3;
    cn(80);
    chk(alarm, 1'b0);
    lnk = 1'b0;
    wait_alarm();
    lnk = 1'b1;
    // The overrun count clears one cycle after the link comes up, so hold the command past it
    pulse(3);
    chk(alarm, 1'b0);
    give_verdict();
  end
endmodule // fcw_top_tb
